// File: verilog/usdp_pkg.sv
// Constants shared by the shadow data port of the UART
package usdp_pkg;

  // Shadow data window: sixteen aliased words, alias 9 sits at 0x50001154
  localparam logic [31:0] USDP_SHADOW_BASE = 32'h5000_1130;
  localparam logic [31:0] USDP_SHADOW9_ADDR = 32'h5000_1154;
  localparam int USDP_ALIAS_COUNT = 16;
  localparam logic [31:0] USDP_SHADOW_SPAN = 32'h0000_0040;

  // Control and status registers of this block
  localparam logic [31:0] USDP_CTRL_ADDR = 32'h5000_1170;
  localparam logic [31:0] USDP_LSTAT_ADDR = 32'h5000_1174;
  localparam logic [31:0] USDP_IRQ_STAT_ADDR = 32'h5000_1178;
  localparam logic [31:0] USDP_IRQ_CLR_ADDR = 32'h5000_117C;
  localparam logic [31:0] USDP_IRQ_EN_ADDR = 32'h5000_1180;

  // Control register fields
  localparam int USDP_CTRL_FIFO_EN_BIT = 0;
  localparam int USDP_CTRL_IR_MODE_BIT = 1;
  localparam logic [1:0] USDP_CTRL_RST = 2'h0;

  // Line status register fields
  localparam int USDP_LSR_DR_BIT = 0;
  localparam int USDP_LSR_OE_BIT = 1;
  localparam int USDP_LSR_TX_HOLDING_EMPTY_FLAG_BIT = 5;
  localparam int USDP_LSR_TXFULL_BIT = 6;

  // Interrupt status, clear and enable fields
  localparam int USDP_IRQ_W = 4;
  localparam int USDP_IRQ_RXD_BIT = 0;
  localparam int USDP_IRQ_OVR_BIT = 1;
  localparam int USDP_IRQ_TX_HOLDING_EMPTY_FLAG_BIT = 2;
  localparam int USDP_IRQ_TXLOST_BIT = 3;
  localparam logic [USDP_IRQ_W-1:0] USDP_IRQ_RST = 4'h0;

  // Data widths and reset values
  localparam int USDP_BYTE_W = 8;
  localparam logic [15:0] USDP_SHADOW_RST = 16'h0000;
  localparam int USDP_FIFO_DEPTH = 16;

endpackage : usdp_pkg

// File: verilog/usdp_top.sv
// Shadow data port of a UART: APB window onto receive and transmit queues
// Overview of operation
// - Sixteen consecutive word addresses all alias the same data port.
// - Reads of bits 7:0 return the byte from serial or infrared input.
// - Read data is valid only while the received-byte-valid flag is set.
// - FIFOs off: new byte overwrites unread byte and flags overrun.
// - FIFOs on: a read returns and removes the receive FIFO head.
// - Receive FIFO full: keep contents, drop new byte, flag overrun.
// - Written byte goes to serial output, or infrared output in IR mode.
// - FIFOs off: writing one byte clears the transmit-holding-empty flag.
// - FIFOs off: further writes before empty replace the pending byte.
// - FIFOs on: transmit FIFO takes bytes up to its depth before full.
// - Write while transmit FIFO full is discarded, contents unchanged.
//
// The implementer's own choice: register access over APB.

// Byte queue that acts as a FIFO or, with fifo_mode low, one holding slot
module usdp_queue #(
  parameter int DEPTH = 16,
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic fifo_mode,
  input wire logic push,
  input wire logic [W-1:0] push_data,
  input wire logic pop,
  output logic [W-1:0] head,
  output logic [$clog2(DEPTH):0] count,
  output logic full,
  output logic empty,
  output logic lost,
  output logic replaced
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;

  wire do_pop = pop & (cnt_r != '0);
  wire is_full = fifo_mode ? (cnt_r == FULL_CNT) : (cnt_r != '0);
  // Full FIFO keeps its contents; single slot is overwritten instead
  wire accept = push & (~fifo_mode | ~is_full | do_pop);
  wire [AW-1:0] rd_nxt = do_pop ? rd_r + 1'b1 : rd_r;
  wire [AW:0] cnt_fifo = cnt_r + (AW+1)'(accept) - (AW+1)'(do_pop);
  wire [AW:0] cnt_nxt = fifo_mode ? cnt_fifo
                      : (push ? (AW+1)'(1) : cnt_r - (AW+1)'(do_pop));
  // Slot mode writes at the next head, so the newest byte wins
  wire [AW-1:0] wr_addr = fifo_mode ? rd_r + cnt_r[AW-1:0] : rd_nxt;

  assign head = mem[rd_r];
  assign count = cnt_r;
  assign full = is_full;
  assign empty = (cnt_r == '0);
  assign lost = push & fifo_mode & is_full & ~do_pop;
  assign replaced = push & ~fifo_mode & (cnt_r != '0) & ~do_pop;

  // Pointers and occupancy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_r <= '0;
      cnt_r <= '0;
    end else if (flush) begin
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage, cleared at reset so the head never reads unknown
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (accept && !flush) begin
      mem[wr_addr] <= push_data;
    end
  end
endmodule : usdp_queue

module usdp_top
  import usdp_pkg::*;
#(
  parameter int RX_DEPTH = USDP_FIFO_DEPTH,
  parameter int TX_DEPTH = USDP_FIFO_DEPTH
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RX_UART_VALID,
  input wire logic [USDP_BYTE_W-1:0] RX_UART_DATA,
  input wire logic RX_IR_VALID,
  input wire logic [USDP_BYTE_W-1:0] RX_IR_DATA,
  output logic TX_UART_VALID,
  output logic TX_IR_VALID,
  input wire logic TX_READY,
  output logic [USDP_BYTE_W-1:0] TX_DATA,
  output logic RX_BYTE_VALID,
  output logic TX_HOLDING_EMPTY,
  output logic OVERRUN,
  output logic IRQ
);
  localparam int RAW = $clog2(RX_DEPTH);
  localparam int TAW = $clog2(TX_DEPTH);

  // Queues need a power-of-two depth of at least two for pointer wrap
  initial begin
    if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0 ||
        TX_DEPTH < 2 || (TX_DEPTH & (TX_DEPTH - 1)) != 0) begin
      $error("usdp_top: FIFO depths must be powers of two, at least 2");
    end
  end

  function automatic logic in_shadow(input logic [31:0] a);
    in_shadow = (a >= USDP_SHADOW_BASE) &&
                (a < USDP_SHADOW_BASE + USDP_SHADOW_SPAN) &&
                (a[1:0] == 2'h0);
  endfunction : in_shadow

  logic [1:0] ctrl_r;
  logic lsr_oe_r;
  logic [USDP_IRQ_W-1:0] irq_stat_r;
  logic [USDP_IRQ_W-1:0] irq_en_r;
  logic tx_holding_empty_flag_q_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic rd_head_ok_r;
  logic [USDP_BYTE_W-1:0] rx_head;
  logic [USDP_BYTE_W-1:0] tx_head;
  logic [RAW:0] rx_cnt;
  logic [TAW:0] tx_cnt;
  logic rx_full;
  logic rx_empty;
  logic rx_lost;
  logic rx_repl;
  logic tx_full;
  logic tx_empty;
  logic tx_lost;

  // Address decode; every word-aligned address of the shadow span answers as one port
  wire hit_shadow = in_shadow(PADDR);
  wire hit_ctrl = (PADDR == USDP_CTRL_ADDR);
  wire hit_lstat = (PADDR == USDP_LSTAT_ADDR);
  wire hit_istat = (PADDR == USDP_IRQ_STAT_ADDR);
  wire hit_iclr = (PADDR == USDP_IRQ_CLR_ADDR);
  wire hit_ien = (PADDR == USDP_IRQ_EN_ADDR);
  wire hit_any = hit_shadow | hit_ctrl | hit_lstat | hit_istat | hit_iclr
                 | hit_ien;

  // Setup is registered into a one-cycle-late ready so read data is a flop
  wire apb_setup = PSEL & ~PENABLE;
  wire apb_done = PSEL & PENABLE & pready_r;
  wire wr_ok = apb_done & PWRITE & ~pslverr_r;
  wire rd_ok = apb_done & ~PWRITE & ~pslverr_r;

  wire fifo_en = ctrl_r[USDP_CTRL_FIFO_EN_BIT];
  wire ir_mode = ctrl_r[USDP_CTRL_IR_MODE_BIT];
  wire [1:0] ctrl_nxt = PWDATA[1:0];
  // Changing FIFO mode empties both queues so no stale byte survives
  wire flush = wr_ok & hit_ctrl &
               (ctrl_nxt[USDP_CTRL_FIFO_EN_BIT] != fifo_en);

  // Receive side: mode picks the source; reads pop the head they saw
  wire rx_push = ir_mode ? RX_IR_VALID : RX_UART_VALID;
  wire [USDP_BYTE_W-1:0] rx_data = ir_mode ? RX_IR_DATA : RX_UART_DATA;
  wire rx_keep_head = ~rx_empty & (fifo_en | ~rx_push);
  wire rx_pop = rd_ok & hit_shadow & rd_head_ok_r;
  wire ovr_evt = rx_lost | rx_repl;

  // Transmit side: master writes push, the active transmitter pops
  wire tx_push = wr_ok & hit_shadow;
  wire tx_pop = TX_READY & ~tx_empty;
  wire tx_holding_empty_flag_rise = tx_empty & ~tx_holding_empty_flag_q_r;

  usdp_queue #(.DEPTH(RX_DEPTH), .W(USDP_BYTE_W)) u_rxq (
    .clk(CLK_SYS),
    .rst_n(RESETN),
    .flush(flush),
    .fifo_mode(fifo_en),
    .push(rx_push),
    .push_data(rx_data),
    .pop(rx_pop),
    .head(rx_head),
    .count(rx_cnt),
    .full(rx_full),
    .empty(rx_empty),
    .lost(rx_lost),
    .replaced(rx_repl)
  );

  usdp_queue #(.DEPTH(TX_DEPTH), .W(USDP_BYTE_W)) u_txq (
    .clk(CLK_SYS),
    .rst_n(RESETN),
    .flush(flush),
    .fifo_mode(fifo_en),
    .push(tx_push),
    .push_data(PWDATA[USDP_BYTE_W-1:0]),
    .pop(tx_pop),
    .head(tx_head),
    .count(tx_cnt),
    .full(tx_full),
    .empty(tx_empty),
    .lost(tx_lost),
    .replaced()
  );

  // Line status and interrupt composition
  wire [31:0] lstat_val = (32'(!rx_empty) << USDP_LSR_DR_BIT)
                        | (32'(lsr_oe_r) << USDP_LSR_OE_BIT)
                        | (32'(tx_empty) << USDP_LSR_TX_HOLDING_EMPTY_FLAG_BIT)
                        | (32'(tx_full) << USDP_LSR_TXFULL_BIT);
  wire [USDP_IRQ_W-1:0] irq_evt =
      (USDP_IRQ_W'(~rx_empty & rx_push & ~rx_lost) << USDP_IRQ_RXD_BIT)
    | (USDP_IRQ_W'(ovr_evt) << USDP_IRQ_OVR_BIT)
    | (USDP_IRQ_W'(tx_holding_empty_flag_rise) << USDP_IRQ_TX_HOLDING_EMPTY_FLAG_BIT)
    | (USDP_IRQ_W'(tx_lost) << USDP_IRQ_TXLOST_BIT);
  wire [USDP_IRQ_W-1:0] irq_clr =
      (wr_ok & hit_iclr) ? PWDATA[USDP_IRQ_W-1:0] : '0;
  // Set wins over clear so an event in the clearing cycle is kept
  wire [USDP_IRQ_W-1:0] irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_evt;
  wire lsr_oe_nxt = ovr_evt | (lsr_oe_r & ~(rd_ok & hit_lstat));

  // Read data mux; reserved bits of the shadow word read zero
  wire [31:0] rdata_nxt =
      hit_shadow ? {16'h0000, USDP_SHADOW_RST[15:8], rx_head}
    : hit_ctrl ? {30'h0000_0000, ctrl_r}
    : hit_lstat ? lstat_val
    : hit_istat ? {28'h000_0000, irq_stat_r}
    : hit_ien ? {28'h000_0000, irq_en_r}
    : 32'h0000_0000;

  // APB answer: ready and error raised for the access phase only
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      rd_head_ok_r <= 1'b0;
    end else begin
      pready_r <= apb_setup;
      pslverr_r <= apb_setup & ~hit_any;
      rd_head_ok_r <= rx_keep_head;
      if (apb_setup && !PWRITE) begin
        prdata_r <= rdata_nxt;
      end
    end
  end

  // Software-visible control and sticky state
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_r <= USDP_CTRL_RST;
      irq_en_r <= USDP_IRQ_RST;
      irq_stat_r <= USDP_IRQ_RST;
      lsr_oe_r <= 1'b0;
      tx_holding_empty_flag_q_r <= 1'b1;
    end else begin
      if (wr_ok && hit_ctrl) begin
        ctrl_r <= ctrl_nxt;
      end
      if (wr_ok && hit_ien) begin
        irq_en_r <= PWDATA[USDP_IRQ_W-1:0];
      end
      irq_stat_r <= irq_stat_nxt;
      lsr_oe_r <= lsr_oe_nxt;
      tx_holding_empty_flag_q_r <= tx_empty;
    end
  end

  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign PRDATA = prdata_r;
  // Pending byte is offered to the transmitter of the active mode only
  assign TX_UART_VALID = ~tx_empty & ~ir_mode;
  assign TX_IR_VALID = ~tx_empty & ir_mode;
  assign TX_DATA = tx_head;
  // Master should wait for this flag before writing; not enforced here
  assign TX_HOLDING_EMPTY = tx_empty;
  assign RX_BYTE_VALID = ~rx_empty;
  assign OVERRUN = ovr_evt;
  assign IRQ = |(irq_stat_r & irq_en_r);

  shadow_alias_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    apb_setup && in_shadow(PADDR) |=> PREADY && !PSLVERR)
    else $error("shadow alias answered with an error");

  rx_source_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    rx_empty && rx_push && !flush |=> rx_head == $past(rx_data)
      && RX_BYTE_VALID)
    else $error("received byte not at receive head");

  rx_invalid_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    rd_ok && hit_shadow && rx_empty && !rx_push |=> !RX_BYTE_VALID)
    else $error("read of empty receive port changed valid flag");

  rx_overwrite_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    !fifo_en && !rx_empty && rx_push && !rx_pop && !flush
      |-> OVERRUN ##1 (rx_cnt == 1 && lsr_oe_r && rx_head == $past(rx_data)))
    else $error("single-slot overrun not handled");

  rx_head_read_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    rx_pop && !rx_empty |-> PRDATA[USDP_BYTE_W-1:0] == rx_head)
    else $error("read did not return receive head");

  rx_full_keep_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    fifo_en && rx_full && rx_push && !rx_pop && !flush
      |=> rx_cnt == $past(rx_cnt) && rx_head == $past(rx_head) && lsr_oe_r)
    else $error("full receive FIFO was altered");

  tx_route_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    tx_empty && tx_push && !flush |=> TX_DATA == $past(PWDATA[7:0])
      && (TX_IR_VALID == ir_mode) && (TX_UART_VALID == !ir_mode))
    else $error("written byte not routed to active transmitter");

  tx_holding_empty_flag_clear_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    !fifo_en && TX_HOLDING_EMPTY && tx_push && !flush |=> !TX_HOLDING_EMPTY)
    else $error("write did not clear holding-empty flag");

  tx_replace_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    !fifo_en && !tx_empty && tx_push && !tx_pop && !flush
      |=> TX_DATA == $past(PWDATA[7:0]) && tx_cnt == 1)
    else $error("pending transmit byte not replaced");

  tx_fill_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    fifo_en && !tx_full && tx_push && !tx_pop && !flush
      |=> tx_cnt == $past(tx_cnt) + 1'b1)
    else $error("transmit FIFO did not accept byte below depth");

  tx_drop_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    fifo_en && tx_full && tx_push && !tx_pop && !flush
      |=> tx_cnt == $past(tx_cnt) && $stable(TX_DATA)
      && irq_stat_r[USDP_IRQ_TXLOST_BIT])
    else $error("write to full transmit FIFO was not discarded");

  alias_pop_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    rx_pop && !rx_empty && !rx_push && !flush
      |=> rx_cnt == $past(rx_cnt) - 1'b1)
    else $error("shadow read did not remove one entry");

endmodule : usdp_top

// File: verif/usdp_peer.sv
// Serial line peer: feeds received bytes and drains the transmitter
module usdp_peer
  import usdp_pkg::*;
(
  input wire logic clk,
  input wire logic tx_uart_valid,
  input wire logic tx_ir_valid,
  input wire logic [USDP_BYTE_W-1:0] tx_data,
  input wire logic stall,
  input wire logic ovr,
  output logic tx_ready,
  output logic rx_uart_valid,
  output logic rx_ir_valid,
  output logic [USDP_BYTE_W-1:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] got[$];
  int n_ovr = 0;

  // A stalled transmitter stands for a slow line
  assign tx_ready = ~stall;

  initial begin
    rx_uart_valid = 1'b0;
    rx_ir_valid = 1'b0;
    rx_data = 8'h00;
  end

  // Log each byte taken with the line it left on, and count overruns
  always @(posedge clk) begin
    if ((tx_uart_valid | tx_ir_valid) & tx_ready)
      got.push_back({tx_ir_valid, tx_data});
    if (ovr)
      n_ovr++;
  end

  // One strobe per character; data is not held afterwards
  task automatic send(input bit ir, input logic [7:0] b);
    @(posedge clk);
    rx_uart_valid <= ~ir;
    rx_ir_valid <= ir;
    rx_data <= b;
    @(posedge clk);
    rx_uart_valid <= 1'b0;
    rx_ir_valid <= 1'b0;
    rx_data <= ~b; // Inverse, so a stale sample shows up
  endtask : send
endmodule : usdp_peer

// File: verif/testbench.sv
// Self-checking bench for the shadow data port
module testbench
  import usdp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, stall = 1;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic pready, pslverr, er, txu, txi, rxu, rxi, rbv, tx_holding_empty_flag, ovr, irq;
  logic tx_rdy;
  logic [7:0] rxd, txd, b1, b2;
  logic [7:0] q[17];
  int seed = 77, miscompares = 0, n_checks = 0, cyc = 0, n0 = 0;

  usdp_top u_dut (.CLK_SYS(clk), .RESETN(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RX_UART_VALID(rxu), .RX_UART_DATA(rxd), .RX_IR_VALID(rxi),
    .RX_IR_DATA(rxd), .TX_UART_VALID(txu), .TX_IR_VALID(txi),
    .TX_READY(tx_rdy), .TX_DATA(txd), .RX_BYTE_VALID(rbv),
    .TX_HOLDING_EMPTY(tx_holding_empty_flag), .OVERRUN(ovr), .IRQ(irq));
  usdp_peer u_peer (.clk(clk), .tx_uart_valid(txu), .tx_ir_valid(txi),
    .tx_data(txd), .stall(stall), .ovr(ovr), .tx_ready(tx_rdy),
    .rx_uart_valid(rxu), .rx_ir_valid(rxi), .rx_data(rxd));

  initial begin
    forever #2 clk = ~clk;
  end

  // Hang guard: the whole run needs a few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  function automatic logic [31:0] al(input int k);
    al = USDP_SHADOW_BASE + 32'(4 * (k % USDP_ALIAS_COUNT));
  endfunction : al

  function automatic logic [31:0] lstat(bit dr, bit oe, bit te, bit fu);
    lstat = 32'h0;
    lstat[USDP_LSR_DR_BIT] = dr;
    lstat[USDP_LSR_OE_BIT] = oe;
    lstat[USDP_LSR_TX_HOLDING_EMPTY_FLAG_BIT] = te;
    lstat[USDP_LSR_TXFULL_BIT] = fu;
  endfunction : lstat

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input bit w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk(er, 0);
  endtask : wr

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  // Let the line take every pending byte, then stall it again
  task automatic drain();
    int n;
    @(posedge clk);
    stall <= 1'b0;
    for (n = 0; n < 200 && tx_holding_empty_flag !== 1'b1; n++) @(negedge clk);
    chk(tx_holding_empty_flag, 1);
    @(posedge clk);
    stall <= 1'b1;
  endtask : drain

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rdc(USDP_LSTAT_ADDR, lstat(0, 0, 1, 0));
    rdc(USDP_CTRL_ADDR, 32'h0);
    rdc(USDP_IRQ_CLR_ADDR, 32'h0);
    apb(1'b0, USDP_SHADOW_BASE - 32'h4, 32'h0);
    chk(er, 1);
    apb(1'b1, USDP_SHADOW_BASE + 32'h1, 32'h0);
    chk(er, 1);
    $display("test reset_map done");
    // Single buffer: read, then overwrite with overrun
    b1 = 8'($random(seed));
    u_peer.send(1'b0, b1);
    @(negedge clk);
    chk(rbv, 1);
    rdc(al($random(seed) & 15), {24'h0, b1});
    chk(rbv, 0);
    apb(1'b0, al(7), 32'h0);
    chk(er, 0);
    chk(rbv, 0);
    b1 = 8'($random(seed));
    b2 = 8'($random(seed));
    n0 = u_peer.n_ovr;
    u_peer.send(1'b0, b1);
    u_peer.send(1'b0, b2);
    @(negedge clk);
    chk(u_peer.n_ovr, n0 + 1);
    rdc(USDP_LSTAT_ADDR, lstat(1, 1, 1, 0));
    rdc(al(0), {24'h0, b2});
    wr(USDP_CTRL_ADDR, 32'h2);
    u_peer.send(1'b1, 8'hA5);
    rdc(al(15), 32'h0000_00A5);
    $display("test rx_single done");
    // Receive FIFO: fill past depth, interrupt, drain by aliases
    wr(USDP_IRQ_CLR_ADDR, 32'hF);
    wr(USDP_IRQ_EN_ADDR, 32'h2);
    wr(USDP_CTRL_ADDR, 32'h1);
    n0 = u_peer.n_ovr;
    for (int i = 0; i < 17; i++) begin
      q[i] = 8'($random(seed));
      u_peer.send(1'b0, q[i]);
    end
    @(negedge clk);
    chk(u_peer.n_ovr, n0 + 1);
    chk(irq, 1);
    wr(USDP_IRQ_EN_ADDR, 32'h0);
    chk(irq, 0);
    wr(USDP_IRQ_EN_ADDR, 32'h2);
    chk(irq, 1);
    wr(USDP_IRQ_CLR_ADDR, 32'hF);
    chk(irq, 0);
    for (int i = 0; i < 16; i++)
      rdc(al(i), {24'h0, q[i]});
    rdc(USDP_LSTAT_ADDR, lstat(0, 1, 1, 0));
    $display("test rx_fifo done");
    // Single holding slot: clear empty, then replace
    wr(USDP_CTRL_ADDR, 32'h0);
    u_peer.got.delete();
    wr(al(3), 32'($random(seed)));
    chk(tx_holding_empty_flag, 0);
    b2 = 8'($random(seed));
    wr(al(4), {24'hFFFFFF, b2});
    chk(txd, b2);
    drain();
    chk(u_peer.got.size(), 1);
    chk(u_peer.got[0], {1'b0, b2});
    wr(USDP_CTRL_ADDR, 32'h2);
    wr(al(5), 32'h0000_003C);
    drain();
    chk(u_peer.got[1], 9'h13C);
    $display("test tx_single done");
    // Transmit FIFO: fill to depth, lose one, drain in order
    wr(USDP_CTRL_ADDR, 32'h1);
    wr(USDP_IRQ_CLR_ADDR, 32'hF);
    u_peer.got.delete();
    for (int i = 0; i < 17; i++) begin
      q[i] = 8'($random(seed));
      if (i == 16)
        rdc(USDP_LSTAT_ADDR, lstat(0, 0, 0, 1));
      wr(al(i + 7), {24'h0, q[i]});
    end
    rdc(USDP_IRQ_STAT_ADDR, 32'h1 << USDP_IRQ_TXLOST_BIT);
    drain();
    chk(u_peer.got.size(), 16);
    for (int i = 0; i < 16; i++)
      chk(u_peer.got[i], {1'b0, q[i]});
    $display("test tx_fifo done");
    wrap_up();
  end
endmodule : testbench
